// ==== core/uhis_status.sv ====
// Interrupt status register, request gating and overrun count.
// Assumes event inputs are one-cycle pulses synchronous to clk and
// that the enable register lives outside and is presented as a word.
`timescale 1ns/100ps
module uhis_status #(
    parameter logic SMI_PRESENT = 1'b1
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [uhis_pkg::ADDR_W-1:0] regAddr,
    input  wire logic                      regWrite,
    input  wire logic                      regRead,
    input  wire logic [31:0]               regWdata,
    output logic      [31:0]               regRdata,
    output logic                           regRdValid,
    input  wire logic [31:0]               hostIntEnable,
    input  wire logic                      ownershipChangeRequest,
    input  wire logic [31:0]               hubStatusWord,
    input  wire logic [127:0]              hubPortStatusWords,
    input  wire logic [15:0]               frameNumber,
    input  wire logic                      sharedFrameUpdated,
    input  wire logic                      systemError,
    input  wire logic                      resumeSignaling,
    input  wire logic                      resumeStateBySoftware,
    input  wire logic                      frameStart,
    input  wire logic                      doneHeadWritten,
    input  wire logic                      scheduleOverrun,
    output logic                           irqOut,
    output logic                           smiOut,
    output logic                           haltProcessing,
    output logic                           doneHeadHold,
    output logic      [1:0]                overrunCount
);

    // ==================================================================
    // Storage
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [1:0]  overrun_reg;
    logic [1:0]  overrun_next;
    logic        frameMsb_reg;
    logic        resume_reg;
    logic        primed_reg;
    logic        irq_reg;
    logic        smi_reg;
    logic [31:0] rdata_reg;
    logic        rdValid_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ==================================================================
    // Change detection for the root hub words
    uhis_chg_if hubChg ();

    assign hubChg.watched = {hubPortStatusWords, hubStatusWord};

    uhis_change_detect u_hub_change (
        .clk (clk),
        .rst (rst),
        .chg (hubChg.detector)
    );

    // ==================================================================
    // Event decode
    logic        statusHit;
    logic        statusWrite;
    logic        statusRead;
    logic        frameMsbToggle;
    logic        resumeRise;
    logic        ownershipEvent;
    logic [31:0] setVec;
    logic [31:0] clrVec;

    assign statusHit   = (regAddr == uhis_pkg::STATUS_OFFSET);
    assign statusWrite = regWrite && statusHit;
    assign statusRead  = regRead && statusHit;

    assign frameMsbToggle = primed_reg &&
        (frameNumber[uhis_pkg::BIT_FRAME_MSB] != frameMsb_reg);

    // Only a rising edge of the device's own signalling counts; a resume
    // that software orders itself is masked out here.
    assign resumeRise = primed_reg && resumeSignaling && !resume_reg &&
        !resumeStateBySoftware;

    // Without a management interrupt line the flag can never be set.
    assign ownershipEvent = ownershipChangeRequest && SMI_PRESENT;

    always_comb begin
        setVec = 32'h00000000;
        setVec[uhis_pkg::BIT_OWNERSHIP]  = ownershipEvent;
        setVec[uhis_pkg::BIT_HUB_CHANGE] = hubChg.changed;
        setVec[uhis_pkg::BIT_FRAME_OVF]  = frameMsbToggle ||
                                           sharedFrameUpdated;
        setVec[uhis_pkg::BIT_UNRECOV]    = systemError;
        setVec[uhis_pkg::BIT_RESUME]     = resumeRise;
        setVec[uhis_pkg::BIT_FRAME_SOF]  = frameStart;
        setVec[uhis_pkg::BIT_DONE_HEAD]  = doneHeadWritten;
        setVec[uhis_pkg::BIT_OVERRUN]    = scheduleOverrun;
    end

    // Reserved positions are masked off, so stray ones do nothing.
    assign clrVec = statusWrite ? (regWdata & uhis_pkg::IMPL_MASK)
                                : 32'h00000000;

    // Hardware only ever ors in events; apart from reset, the sole clear path is clrVec.
    assign status_next = uhis_pkg::w1c_next(status_reg, clrVec,
                                            setVec);

    assign overrun_next = scheduleOverrun ?
        (overrun_reg + uhis_pkg::OVERRUN_STEP) : overrun_reg;

    // ==================================================================
    // Request gating
    logic irq_next;
    logic smi_next;

    // Decided from the next flag value so the request follows the event
    // in the same edge as the flag itself.
    assign irq_next = hostIntEnable[uhis_pkg::BIT_MASTER_EN] &&
        uhis_pkg::any_enabled(status_next, hostIntEnable,
                              uhis_pkg::IRQ_MASK);

    assign smi_next = SMI_PRESENT &&
        status_next[uhis_pkg::BIT_OWNERSHIP] &&
        hostIntEnable[uhis_pkg::BIT_OWNERSHIP];

    // ==================================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            status_reg  <= uhis_pkg::STATUS_RESET;
            overrun_reg <= uhis_pkg::OVERRUN_RESET;
            primed_reg  <= 1'b0;
            irq_reg     <= 1'b0;
            smi_reg     <= 1'b0;
        end else begin
            status_reg  <= status_next;
            overrun_reg <= overrun_next;
            primed_reg  <= 1'b1;
            irq_reg     <= irq_next;
            smi_reg     <= smi_next;
        end
    end

    // History copies are not reset; primed_reg masks their first compare after reset.
    always_ff @(posedge clk) begin
        frameMsb_reg <= frameNumber[uhis_pkg::BIT_FRAME_MSB];
        resume_reg   <= resumeSignaling;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg   <= 32'h00000000;
            rdValid_reg <= 1'b0;
        end else begin
            rdata_reg   <= statusRead ? status_reg : 32'h00000000;
            rdValid_reg <= regRead;
        end
    end

    // ==================================================================
    // Outputs
    assign regRdata       = rdata_reg;
    assign regRdValid     = rdValid_reg;
    assign irqOut         = irq_reg;
    assign smiOut         = smi_reg;
    assign overrunCount   = overrun_reg;
    // The error flag is the halt; software resets the controller before
    // clearing it, so processing does not restart on its own.
    assign haltProcessing = status_reg[uhis_pkg::BIT_UNRECOV];
    // The write-back engine must wait until software has saved the head.
    assign doneHeadHold   = status_reg[uhis_pkg::BIT_DONE_HEAD];

    // ==================================================================
    // Checks
    a_error_sets_flag: assert property (
        systemError |=> status_reg[uhis_pkg::BIT_UNRECOV] && haltProcessing
    ) else $error("System error did not set the halt flag.");

    a_irq_needs_master: assert property (
        $rose(irqOut) |-> $past(hostIntEnable[uhis_pkg::BIT_MASTER_EN]) &&
            |(status_reg & $past(hostIntEnable) & uhis_pkg::IRQ_MASK)
    ) else $error("Interrupt raised without master and bit enable.");

    a_write_clears: assert property (
        statusWrite && regWdata[uhis_pkg::BIT_FRAME_SOF] && !frameStart
        |=> !status_reg[uhis_pkg::BIT_FRAME_SOF]
    ) else $error("Write of one did not clear the frame start flag.");

    a_no_soft_set: assert property (
        $rose(status_reg[uhis_pkg::BIT_UNRECOV]) |-> $past(systemError)
    ) else $error("Error flag set without a system error.");

    a_no_hw_clear: assert property (
        ($past(status_reg) & ~status_reg) ==
        ($past(status_reg) & ~status_reg & $past(clrVec))
    ) else $error("A flag dropped without a software clear.");

    a_reserved_zero: assert property (
        (status_reg & ~uhis_pkg::IMPL_MASK) == 32'h00000000
    ) else $error("Reserved status bit reads nonzero.");

    a_ownership_smi: assert property (
        ownershipChangeRequest && SMI_PRESENT &&
        hostIntEnable[uhis_pkg::BIT_OWNERSHIP]
        |=> status_reg[uhis_pkg::BIT_OWNERSHIP] && smiOut
    ) else $error("Ownership change did not raise management interrupt.");

    a_no_smi_held: assert property (
        !SMI_PRESENT |-> !status_reg[uhis_pkg::BIT_OWNERSHIP] && !smiOut
    ) else $error("Ownership flag set without management line.");

    a_hub_change: assert property (
        $changed({hubPortStatusWords, hubStatusWord}) && !$past(rst)
        |=> status_reg[uhis_pkg::BIT_HUB_CHANGE]
    ) else $error("Hub status change not flagged.");

    a_frame_toggle: assert property (
        $changed(frameNumber[uhis_pkg::BIT_FRAME_MSB]) && !$past(rst)
        |=> status_reg[uhis_pkg::BIT_FRAME_OVF]
    ) else $error("Frame counter msb toggle not flagged.");

    a_resume_sw_mask: assert property (
        $rose(status_reg[uhis_pkg::BIT_RESUME])
        |-> $past(resumeSignaling) && !$past(resumeStateBySoftware)
    ) else $error("Resume flag set without device resume edge.");

    a_done_head_hold: assert property (
        doneHeadWritten |=> doneHeadHold [*2] or
            (doneHeadHold ##1 !doneHeadHold && $past(clrVec[1]))
    ) else $error("Done head write-back not held after flag set.");

    a_overrun_count: assert property (
        scheduleOverrun |=> overrunCount == $past(overrunCount) + 2'h1 &&
            status_reg[uhis_pkg::BIT_OVERRUN]
    ) else $error("Overrun count or flag did not follow overrun.");

    a_overrun_steady: assert property (
        !scheduleOverrun |=> $stable(overrunCount)
    ) else $error("Overrun count moved without an overrun.");

endmodule

// ==== core/uhis_pkg.sv ====
// Constants, field positions and helpers for the host interrupt status block.
// Assumes one controller clock and a synchronous, active-high reset.
package uhis_pkg;

    // ==================================================================
    // Register map
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  STATUS_OFFSET = 8'h0c;
    localparam logic [31:0] STATUS_RESET  = 32'h00000000;

    // ==================================================================
    // Field positions
    localparam int BIT_OVERRUN    = 0;
    localparam int BIT_DONE_HEAD  = 1;
    localparam int BIT_FRAME_SOF  = 2;
    localparam int BIT_RESUME     = 3;
    localparam int BIT_UNRECOV    = 4;
    localparam int BIT_FRAME_OVF  = 5;
    localparam int BIT_HUB_CHANGE = 6;
    localparam int BIT_OWNERSHIP  = 30;
    localparam int BIT_MASTER_EN  = 31;
    localparam int BIT_FRAME_MSB  = 15;

    localparam logic [31:0] IMPL_MASK = 32'h4000007f;
    localparam logic [31:0] IRQ_MASK  = 32'h0000007f;

    // ==================================================================
    // Widths and reset values
    localparam int         FRAME_W       = 16;
    localparam int         NUM_PORTS     = 4;
    localparam int         HUB_WATCH_W   = DATA_W * (1 + NUM_PORTS);
    localparam logic [1:0] OVERRUN_RESET = 2'h0;
    localparam logic [1:0] OVERRUN_STEP  = 2'h1;

    // ==================================================================
    // Helpers
    function automatic logic [31:0] w1c_next(
        input logic [31:0] cur,
        input logic [31:0] clr,
        input logic [31:0] set
    );
        // Set wins over a clear that lands in the same cycle.
        w1c_next = ((cur & ~clr) | set) & IMPL_MASK;
    endfunction

    function automatic logic any_enabled(
        input logic [31:0] flags,
        input logic [31:0] enables,
        input logic [31:0] mask
    );
        any_enabled = |(flags & enables & mask);
    endfunction

endpackage

// ==== core/uhis_chg_if.sv ====
// Carrier between the status logic and its change detector.
// Assumes both ends share the controller clock.
`timescale 1ns/100ps
interface uhis_chg_if;
    logic [uhis_pkg::HUB_WATCH_W-1:0] watched;
    logic                             changed;

    modport detector (
        input  watched,
        output changed
    );
    modport owner (
        output watched,
        input  changed
    );
endinterface

// ==== core/uhis_change_detect.sv ====
// Content-change detector for the root hub status words.
// Assumes the watched word is synchronous to clk.
`timescale 1ns/100ps
module uhis_change_detect (
    input  wire logic        clk,
    input  wire logic        rst,
    uhis_chg_if.detector     chg
);
    logic [uhis_pkg::HUB_WATCH_W-1:0] prev_reg;
    logic                             primed_reg;

    // ==================================================================
    // Capture
    // The previous copy needs no reset; the primed flag keeps the first
    // cycle after reset from reporting a false change.
    always_ff @(posedge clk) begin
        prev_reg <= chg.watched;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            primed_reg <= 1'b0;
        end else begin
            primed_reg <= 1'b1;
        end
    end

    // ==================================================================
    // Compare
    assign chg.changed = primed_reg && (chg.watched != prev_reg);

endmodule

// ==== tb/usb_host_interrupt_status_tb.sv ====
// Self-checking bench for the host interrupt status block.
// Assumes the core/ files are compiled first; the bench drives every port.
`timescale 1ns/100ps
module usb_host_interrupt_status_tb;
    // ==================================================================
    // Signals
    logic         clk;
    logic         rst;
    logic [7:0]   regAddr;
    logic         regWrite;
    logic         regRead;
    logic [31:0]  regWdata;
    logic [31:0]  regRdata;
    logic         regRdValid;
    logic [31:0]  hostIntEnable;
    logic [31:0]  hubWord;
    logic [127:0] portWords;
    logic [15:0]  frameNumber;
    logic         ownReq, resumeSw, resumeSig, sysErr;
    logic         frameStart, doneHead, sched, sharedFrame;
    logic         irqOut, smiOut, haltOut, holdOut, nsSmi;
    logic [1:0]   ovrCount;
    logic [31:0]  nsRdata;
    logic [31:0]  expStat, expRd;
    logic         expValid, expIrq, expSmi, prevFn15, prevRes;
    logic [1:0]   expCnt;
    logic [159:0] prevHub;
    int           bad_count, check_count, seed, i, r;

    // ==================================================================
    // Devices under test: with and without the management line
    uhis_status uut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .regRdValid(regRdValid),
        .hostIntEnable(hostIntEnable), .ownershipChangeRequest(ownReq),
        .hubStatusWord(hubWord), .hubPortStatusWords(portWords),
        .frameNumber(frameNumber), .sharedFrameUpdated(sharedFrame),
        .systemError(sysErr), .resumeSignaling(resumeSig),
        .resumeStateBySoftware(resumeSw), .frameStart(frameStart),
        .doneHeadWritten(doneHead), .scheduleOverrun(sched),
        .irqOut(irqOut), .smiOut(smiOut), .haltProcessing(haltOut),
        .doneHeadHold(holdOut), .overrunCount(ovrCount));
    uhis_status #(.SMI_PRESENT(1'b0)) uutNoSmi (.clk(clk), .rst(rst),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(nsRdata), .regRdValid(),
        .hostIntEnable(hostIntEnable), .ownershipChangeRequest(ownReq),
        .hubStatusWord(hubWord), .hubPortStatusWords(portWords),
        .frameNumber(frameNumber), .sharedFrameUpdated(sharedFrame),
        .systemError(sysErr), .resumeSignaling(resumeSig),
        .resumeStateBySoftware(resumeSw), .frameStart(frameStart),
        .doneHeadWritten(doneHead), .scheduleOverrun(sched),
        .irqOut(), .smiOut(nsSmi), .haltProcessing(), .doneHeadHold(),
        .overrunCount());

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==================================================================
    // Next status word: a set wins over a clear in the same cycle.
    function automatic logic [31:0] exp_status(input logic [31:0] cur,
        input logic [31:0] clr, input logic [31:0] set);
        exp_status = ((cur & ~clr) | set) & 32'h4000007f;
    endfunction

    // Reference model, evaluated on the same edge the design samples.
    always @(posedge clk) begin : model
        logic [31:0] setv;
        logic [31:0] clrv;
        setv = 32'h0;
        setv[0] = sched;
        setv[1] = doneHead;
        setv[2] = frameStart;
        setv[3] = resumeSig & ~prevRes & ~resumeSw;
        setv[4] = sysErr;
        setv[5] = sharedFrame | (frameNumber[15] ^ prevFn15);
        setv[6] = ({hubWord, portWords} != prevHub);
        setv[30] = ownReq;
        clrv = (regWrite && regAddr == 8'h0c) ? regWdata : 32'h0;
        expValid = regRead & ~rst;
        if (regRead) begin
            expRd = (regAddr == 8'h0c && !rst) ? expStat : 32'h0;
        end
        expStat = rst ? 32'h0 : exp_status(expStat, clrv, setv);
        expCnt = rst ? 2'h0 : expCnt + {1'b0, sched};
        expIrq = |(expStat[6:0] & hostIntEnable[6:0]) & hostIntEnable[31];
        expSmi = expStat[30] & hostIntEnable[30];
        prevHub = {hubWord, portWords};
        prevFn15 = frameNumber[15];
        prevRes = resumeSig;
    end

    // ==================================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One clock: compare all outputs, then apply the next cycle's inputs.
    // Event vector: own, swResume, resume, sysErr, sof, done, overrun, shared.
    task automatic step(input logic wr, input logic rd, input logic [7:0] a,
                        input logic [31:0] d, input logic [7:0] ev);
        @(posedge clk);
        #1;
        check(regRdValid, expValid);
        if (expValid) check(regRdata, expRd);
        check(irqOut, expIrq);
        check(smiOut, expSmi);
        check({haltOut, holdOut}, {expStat[4], expStat[1]});
        check(ovrCount, expCnt);
        check(nsSmi, 1'b0);
        if (expValid) check(nsRdata, expRd & 32'hbfffffff);
        regWrite = wr;
        regRead = rd;
        regAddr = a;
        regWdata = d;
        {ownReq, resumeSw, resumeSig, sysErr} = ev[7:4];
        {frameStart, doneHead, sched, sharedFrame} = ev[3:0];
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        seed = 16699;
        bad_count = 0;
        check_count = 0;
        rst = 1'b1;
        {regWrite, regRead, regAddr, regWdata} = 42'h0;
        {ownReq, resumeSw, resumeSig, sysErr} = 4'h0;
        {frameStart, doneHead, sched, sharedFrame} = 4'h0;
        {hostIntEnable, hubWord, portWords, frameNumber} = 208'h0;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) step(1'b0, 1'b1, 8'h0c, 32'h0, 8'h0);
        hostIntEnable = 32'hc000007f;
        // Every event alone, each followed by a read and a full clear.
        for (i = 0; i < 8; i++) begin
            step(1'b0, 1'b0, 8'h0, 32'h0, 8'h1 << i);
            step(1'b0, 1'b1, 8'h0c, 32'h0, 8'h0);
            step(1'b1, 1'b1, 8'h0c, 32'h4000007f, 8'h0);
        end
        hubWord = 32'h00000101;
        step(1'b0, 1'b0, 8'h0, 32'h0, 8'h0);
        frameNumber = 16'h8000;
        step(1'b0, 1'b1, 8'h0c, 32'h0, 8'h0);
        // Resume entered by software must not flag.
        step(1'b0, 1'b0, 8'h0, 32'h0, 8'h60);
        step(1'b0, 1'b1, 8'h0c, 32'h0, 8'h20);
        // Zero writes and reserved-bit writes leave the flags alone.
        step(1'b1, 1'b0, 8'h0c, 32'h0, 8'h0);
        step(1'b1, 1'b1, 8'h0c, 32'hbfffff80, 8'h0);
        step(1'b1, 1'b1, 8'h10, 32'hffffffff, 8'h0);
        // Set beats a clear in the same cycle; count wraps past three.
        step(1'b1, 1'b1, 8'h0c, 32'hffffffff, 8'h08);
        repeat (5) step(1'b0, 1'b1, 8'h0c, 32'h0, 8'h02);
        // Random traffic; the model tracks every flag and output.
        for (i = 0; i < 3000; i++) begin
            r = $random(seed);
            step(r[0] & r[1], r[2], r[3] ? 8'h0c : r[15:8], $random(seed),
                 r[23:16] & r[31:24]);
            if (r[6:4] == 3'h7) portWords[127:96] = $random(seed);
            if (r[6:4] == 3'h6) hubWord = $random(seed);
            if (r[6:4] == 3'h5) frameNumber = frameNumber + 16'h3001;
            if (r[6:4] == 3'h4) hostIntEnable = $random(seed);
        end
        // Reset in mid-run must clear status and count.
        {hubWord, portWords, frameNumber} = 176'h0;
        step(1'b0, 1'b0, 8'h0, 32'h0, 8'h0);
        // A system error just before the reset; software clears the error
        // flag only once the controller has been reset.
        step(1'b0, 1'b0, 8'h0, 32'h0, 8'h10);
        step(1'b0, 1'b0, 8'h0, 32'h0, 8'h0);
        rst = 1'b1;
        repeat (2) step(1'b0, 1'b0, 8'h0, 32'h0, 8'h0);
        rst = 1'b0;
        step(1'b1, 1'b1, 8'h0c, 32'h00000010, 8'h0);
        repeat (3) step(1'b0, 1'b1, 8'h0c, 32'h0, 8'h0);
        tally_and_finish();
    end

    // A hang is cut short and counted as a mismatch.
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish();
    end
endmodule
